/* File: agl_cfg.svh */
// agl_cfg.svh: timing counts, base address, field positions and codes for the converter glue
// assumes a 100 MHz i_clock; included by agl_host, agl_sync and the testbench
`ifndef AGL_CFG_SVH
`define AGL_CFG_SVH
`define AGL_CLK_PERIOD_NS     10
`define AGL_PULSE_NS          400
`define AGL_PULSE_CYC         ((`AGL_PULSE_NS + `AGL_CLK_PERIOD_NS - 1) / `AGL_CLK_PERIOD_NS)
`define AGL_READ_NS           300
`define AGL_READ_CYC          ((`AGL_READ_NS + `AGL_CLK_PERIOD_NS - 1) / `AGL_CLK_PERIOD_NS)
`define AGL_RECOVER_NS        200
`define AGL_RECOVER_CYC       ((`AGL_RECOVER_NS + `AGL_CLK_PERIOD_NS - 1) / `AGL_CLK_PERIOD_NS)
`define AGL_CONV_WAIT_US      10
`define AGL_CONV_WAIT_CYC     ((`AGL_CONV_WAIT_US * 1000) / `AGL_CLK_PERIOD_NS)
`define AGL_STAT_TIMEOUT_CYC  16'h0FA0
`define AGL_CONV_BASE         10'h310
`define AGL_MUX_BASE          10'h300
`define AGL_REG_CTRL          4'h0
`define AGL_REG_CHAN          4'h1
`define AGL_REG_RESULT        4'h2
`define AGL_REG_STATUS        4'h3
`define AGL_REG_IRQ_STAT      4'h4
`define AGL_REG_IRQ_MASK      4'h5
`define AGL_CTRL_START_BIT    2
`define AGL_IRQ_DONE_BIT      0
`define AGL_IRQ_TIMEOUT_BIT   1
`endif

/* File: agl_conv_model.sv */
// agl_conv_model.sv: behavioural 8-bit converter answering the glue's select pins
// assumes selects come from registered outputs on i_clock; result encodes channel and format
// i_mute makes the converter ignore every start, so the glue's timeout path can be reached
`timescale 1ns/10ps
module agl_conv_model #(
    parameter int CONV_CYC = 20
) (
    input  wire logic       i_clock,
    input  wire logic       i_cs_n,
    input  wire logic       i_ce_n,
    input  wire logic       i_rw,
    input  wire logic [1:0] i_format,
    input  wire logic [1:0] i_chan,
    input  wire logic       i_mute,
    output logic            o_status,
    output logic [7:0]      o_data
);
    int         low_cnt = 0;
    int         conv_cnt = 0;
    logic [7:0] result = 8'h00;
    logic [7:0] float_q = 8'h5A;
    initial o_status = 1'b0;
    always @(posedge i_clock) begin
        low_cnt <= (!i_cs_n && !i_ce_n && !i_rw && !o_status) ? low_cnt + 1 : 0;
        float_q <= ~float_q;
        if (o_status) begin
            conv_cnt <= conv_cnt - 1;
            if (conv_cnt == 1) o_status <= 1'b0;
        end else if (low_cnt == 29 && !i_mute) begin
            o_status <= 1'b1;
            conv_cnt <= CONV_CYC;
            result   <= {4'hA, i_chan, i_format};
        end
    end
    // a released bus toggles so a stale value can never pass for data
    assign o_data = (!o_status && i_rw && !i_cs_n && !i_ce_n) ? result : float_q;
endmodule

/* File: agl_host.sv */
// agl_host.sv: host-side bus glue driving an 8-bit converter and a 4-channel mux latch
// assumes a plain register port from software, the converter pins wired directly,
// and that the converter keeps its own status and conversion timing
// Summary of operation
// - status stays high for the whole conversion and a registered copy of it is the sample/hold hold command.
// - the external hold path must open the sampling switch within 150 ns of status rising.
// - the mux address decode gated with the write strobe latches two data bits as the channel.
// - chip select is decoded from address lines 9 to 1 and not gated by the DMA qualifier, which is held low except during reset, when it is driven high.
// - address bit zero drives read/write select, so start and result sit on adjacent addresses.
// - read and write strobes are gated together onto chip enable.
// - on a start write the two low data lines set coding and polarity, upper six bits ignored.
// - the result is read only after about ten microseconds past the start write.
// - read/write select low requests a start, high requests a data read.
`timescale 1ns/10ps
`include "agl_cfg.svh"
module agl_host #(
    parameter int CONV_WAIT_CYC = `AGL_CONV_WAIT_CYC
) (
    input  wire logic       i_clock,
    input  wire logic       i_srst,
    input  wire logic [3:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    output logic [7:0]      o_reg_rdata,
    output logic            o_irq,
    input  wire logic       i_conv_status,
    input  wire logic [7:0] i_conv_data,
    output logic [9:0]      o_io_addr,
    output logic            o_dma_cycle_qualifier,
    output logic            o_host_io_read_n,
    output logic            o_host_io_write_n,
    output logic [7:0]      o_io_wdata,
    output logic            o_io_wdata_oe,
    output logic            o_conv_cs_n,
    output logic            o_conv_ce_n,
    output logic            o_conv_rw,
    output logic [1:0]      o_conv_format,
    output logic [1:0]      o_mux_chan,
    output logic            o_hold
);
    logic              status_s;
    agl_pkg::agl_state_t state_q, state_d;
    logic [15:0]       cnt_q, cnt_d;
    logic [15:0]       wait_q, wait_d;
    logic [1:0]        fmt_q;
    logic [1:0]        chan_req_q;
    logic [7:0]        result_q;
    logic [1:0]        irq_stat_q, irq_mask_q;
    logic              seen_status_q;
    logic              chan_pend_q;

    agl_sync u_status_sync (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_async (i_conv_status),
        .o_sync  (status_s)
    );

    // software decode
    wire wr_ctrl   = i_reg_wr && (i_reg_addr == `AGL_REG_CTRL);
    wire wr_chan   = i_reg_wr && (i_reg_addr == `AGL_REG_CHAN);
    wire wr_istat  = i_reg_wr && (i_reg_addr == `AGL_REG_IRQ_STAT);
    wire wr_imask  = i_reg_wr && (i_reg_addr == `AGL_REG_IRQ_MASK);
    wire start_req = wr_ctrl && i_reg_wdata[`AGL_CTRL_START_BIT];
    wire idle      = (state_q == agl_pkg::AGL_IDLE);
    wire busy      = !idle || chan_pend_q;

    // bus cycle phases seen on the pins
    wire in_mux   = (state_q == agl_pkg::AGL_MUXWR);
    wire in_start = (state_q == agl_pkg::AGL_START);
    wire in_read  = (state_q == agl_pkg::AGL_READ);
    wire cnt_done = (cnt_q == 16'h0000);
    wire wait_done = (wait_q == 16'h0000);

    // addresses: A0 selects start (low) or result (high)
    wire [9:0] addr_d = in_mux  ? `AGL_MUX_BASE :
                        in_read ? (`AGL_CONV_BASE | 10'h001) : `AGL_CONV_BASE;
    // chip select from a nine-bit decode of address bits 9 to 1, gated to the start and read phases
    wire cs_hit = (addr_d[9:1] == 9'(`AGL_CONV_BASE >> 1)) && (in_start || in_read);
    wire ior_d  = !in_read;
    wire iow_d  = !(in_mux || in_start);
    // both strobes combined onto chip enable
    wire ce_d   = ior_d && iow_d;
    wire timeout = (state_q == agl_pkg::AGL_WAIT) && wait_done && !seen_status_q;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        wait_d  = wait_q;
        if (!cnt_done) begin
            cnt_d = cnt_q - 16'h0001;
        end
        if (!wait_done) begin
            wait_d = wait_q - 16'h0001;
        end
        case (state_q)
            agl_pkg::AGL_IDLE: begin
                if (chan_pend_q) begin
                    state_d = agl_pkg::AGL_MUXWR;
                    cnt_d   = 16'(`AGL_PULSE_CYC);
                end else if (start_req) begin
                    state_d = agl_pkg::AGL_START;
                    cnt_d   = 16'(`AGL_PULSE_CYC);
                end
            end
            agl_pkg::AGL_MUXWR: begin
                if (cnt_done) begin
                    state_d = agl_pkg::AGL_RECOV;
                    cnt_d   = 16'(`AGL_RECOVER_CYC);
                end
            end
            agl_pkg::AGL_START: begin
                // selects held low past the minimum before release
                if (cnt_done) begin
                    state_d = agl_pkg::AGL_WAIT;
                    wait_d  = CONV_WAIT_CYC[15:0];
                end
            end
            agl_pkg::AGL_WAIT: begin
                // read only after the full wait and once status has fallen
                if (wait_done && seen_status_q && !status_s) begin
                    state_d = agl_pkg::AGL_READ;
                    cnt_d   = 16'(`AGL_READ_CYC);
                end else if (timeout) begin
                    state_d = agl_pkg::AGL_RECOV;
                    cnt_d   = 16'(`AGL_RECOVER_CYC);
                end
            end
            agl_pkg::AGL_READ: begin
                if (cnt_done) begin
                    state_d = agl_pkg::AGL_RECOV;
                    cnt_d   = 16'(`AGL_RECOVER_CYC);
                end
            end
            agl_pkg::AGL_RECOV: begin
                if (cnt_done) begin
                    state_d = agl_pkg::AGL_IDLE;
                end
            end
            default: begin
                state_d = agl_pkg::AGL_IDLE;
            end
        endcase
    end

    // result captured at the end of the read strobe, after bus access time
    wire take_result = in_read && cnt_done;
    wire done_ev     = take_result;
    wire [1:0] ev    = {timeout, done_ev};
    wire [7:0] stat_rd = {5'h00, status_s, chan_pend_q, busy};
    wire [7:0] rdata_d = (i_reg_addr == `AGL_REG_CTRL)     ? {6'h00, fmt_q} :
                         (i_reg_addr == `AGL_REG_CHAN)     ? {6'h00, o_mux_chan} :
                         (i_reg_addr == `AGL_REG_RESULT)   ? result_q :
                         (i_reg_addr == `AGL_REG_STATUS)   ? stat_rd :
                         (i_reg_addr == `AGL_REG_IRQ_STAT) ? {6'h00, irq_stat_q} :
                         (i_reg_addr == `AGL_REG_IRQ_MASK) ? {6'h00, irq_mask_q} : 8'h00;
    // set wins over a write-one clear in the same cycle
    wire [1:0] istat_d = (irq_stat_q & ~(wr_istat ? i_reg_wdata[1:0] : 2'h0)) | ev;
    wire [7:0] wdata_d = in_mux ? {6'h00, chan_req_q} : {6'h00, fmt_q};

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_q <= agl_pkg::AGL_IDLE;
            cnt_q   <= 16'h0000;
            wait_q  <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            wait_q  <= wait_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            fmt_q       <= 2'h0;
            chan_req_q  <= 2'h0;
            chan_pend_q <= 1'b0;
            o_mux_chan  <= 2'h0;
        end else begin
            // a new setting is taken only between conversions; upper bits dropped
            if (start_req && idle && !chan_pend_q) begin
                fmt_q <= i_reg_wdata[1:0];
            end
            if (wr_chan && !busy) begin
                chan_req_q  <= i_reg_wdata[1:0];
                chan_pend_q <= 1'b1;
            end else if (in_mux && cnt_done) begin
                chan_pend_q <= 1'b0;
                // latch takes the two low data bits on the gated mux strobe
                o_mux_chan  <= chan_req_q;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            seen_status_q <= 1'b0;
            result_q      <= 8'h00;
            irq_stat_q    <= 2'h0;
            irq_mask_q    <= 2'h0;
            o_reg_rdata   <= 8'h00;
            o_irq         <= 1'b0;
        end else begin
            if (in_start) begin
                seen_status_q <= 1'b0;
            end else if (status_s) begin
                seen_status_q <= 1'b1;
            end
            if (take_result) begin
                result_q <= i_conv_data;
            end
            irq_stat_q <= istat_d;
            if (wr_imask) begin
                irq_mask_q <= i_reg_wdata[1:0];
            end
            o_reg_rdata <= i_reg_rd ? rdata_d : 8'h00;
            o_irq       <= |(istat_d & (wr_imask ? i_reg_wdata[1:0] : irq_mask_q));
        end
    end

    // pin drivers, all registered
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_io_addr             <= `AGL_CONV_BASE;
            o_dma_cycle_qualifier <= 1'b1;
            o_host_io_read_n      <= 1'b1;
            o_host_io_write_n     <= 1'b1;
            o_io_wdata            <= 8'h00;
            o_io_wdata_oe         <= 1'b0;
            o_conv_cs_n           <= 1'b1;
            o_conv_ce_n           <= 1'b1;
            o_conv_rw             <= 1'b1;
            o_conv_format         <= 2'h0;
            o_hold                <= 1'b0;
        end else begin
            o_io_addr             <= addr_d;
            o_dma_cycle_qualifier <= 1'b0;
            o_host_io_read_n      <= ior_d;
            o_host_io_write_n     <= iow_d;
            o_io_wdata            <= wdata_d;
            o_io_wdata_oe         <= !iow_d;
            o_conv_cs_n           <= !cs_hit;
            o_conv_ce_n           <= ce_d;
            o_conv_rw             <= addr_d[0];
            o_conv_format         <= wdata_d[1:0];
            // hold follows the pin directly; a synchronised copy would add 20 ns of skew
            o_hold                <= i_conv_status;
        end
    end
endmodule

/* File: agl_host_sva.sv */
// agl_host_sva.sv: concurrent checks on the converter and mux pins of the bus glue
// assumes it is bound to agl_host and sees only that module's ports
`timescale 1ns/10ps
module agl_host_sva (
    input wire logic       i_clock,
    input wire logic       i_srst,
    input wire logic       i_conv_status,
    input wire logic [9:0] o_io_addr,
    input wire logic       o_dma_cycle_qualifier,
    input wire logic       o_host_io_read_n,
    input wire logic       o_host_io_write_n,
    input wire logic [7:0] o_io_wdata,
    input wire logic       o_io_wdata_oe,
    input wire logic       o_conv_cs_n,
    input wire logic       o_conv_ce_n,
    input wire logic       o_conv_rw,
    input wire logic [1:0] o_conv_format,
    input wire logic [1:0] o_mux_chan,
    input wire logic       o_hold
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    sequence start_edge;
        $fell(o_host_io_write_n) && !o_conv_cs_n && !o_conv_rw;
    endsequence
    chk_ce_gating: assert property (
        o_conv_ce_n == (o_host_io_read_n & o_host_io_write_n))
        else $error("chip enable is not the gated strobes");
    chk_cs_decode: assert property (
        !o_conv_cs_n |-> o_io_addr[9:1] == 9'h188 && !o_dma_cycle_qualifier)
        else $error("chip select outside the converter pair");
    chk_rw_addr: assert property (!o_conv_cs_n |-> o_conv_rw == o_io_addr[0])
        else $error("read/write select differs from address bit zero");
    chk_mux_no_cs: assert property (
        !o_host_io_write_n && o_io_addr == 10'h300 |-> o_conv_cs_n)
        else $error("converter selected during a mux write");
    chk_start_format: assert property (
        start_edge |-> o_conv_format == o_io_wdata[1:0] && o_io_wdata_oe)
        else $error("format lines differ from low data lines");
    chk_start_width: assert property (
        start_edge |-> ##29 (!o_host_io_write_n && !o_conv_cs_n))
        else $error("start pulse shorter than 300 ns");
    chk_read_rw: assert property (
        !o_host_io_read_n |-> o_conv_rw && o_host_io_write_n)
        else $error("read strobe without read select");
    chk_hold_copy: assert property (
        !$past(i_srst) |-> o_hold == $past(i_conv_status))
        else $error("hold does not follow status");
    chk_chan_latch: assert property (
        $changed(o_mux_chan) |-> $past(o_io_addr) == 10'h300)
        else $error("channel changed without a mux write");
    chk_oe_write: assert property (o_io_wdata_oe == !o_host_io_write_n)
        else $error("data enable differs from write strobe");
endmodule
bind agl_host agl_host_sva chk_u (.i_clock, .i_srst, .i_conv_status, .o_io_addr,
    .o_dma_cycle_qualifier, .o_host_io_read_n, .o_host_io_write_n, .o_io_wdata, .o_io_wdata_oe,
    .o_conv_cs_n, .o_conv_ce_n, .o_conv_rw, .o_conv_format, .o_mux_chan, .o_hold);

/* File: agl_pkg.sv */
// agl_pkg.sv: shared types for the converter glue
// assumes agl_cfg.svh is on the include path
package agl_pkg;
    typedef enum logic [2:0] {
        AGL_IDLE   = 3'b000,
        AGL_MUXWR  = 3'b001,
        AGL_START  = 3'b010,
        AGL_WAIT   = 3'b011,
        AGL_READ   = 3'b100,
        AGL_RECOV  = 3'b101
    } agl_state_t;
    // two-bit setting driven on the low data lines at the start write
    typedef enum logic [1:0] {
        AGL_UNI_STRAIGHT = 2'h0,
        AGL_BI_OFFSET    = 2'h1,
        AGL_UNI_TWOS     = 2'h2,
        AGL_BI_TWOS      = 2'h3
    } agl_format_t;
endpackage

/* File: agl_sync.sv */
// agl_sync.sv: two-flop synchroniser for one pin
// assumes the pin is asynchronous to i_clock
`timescale 1ns/10ps
`include "agl_cfg.svh"
module agl_sync (
    input  wire logic i_clock,
    input  wire logic i_srst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_q;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            meta_q <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

/* File: test_adc_host_bus_glue.sv */
// test_adc_host_bus_glue.sv: self-checking bench for agl_host with a converter model
// assumes agl_cfg.svh on the include path and a shortened conversion wait
`timescale 1ns/10ps
`include "agl_cfg.svh"
module test_adc_host_bus_glue;
    logic i_clock = 1'b0, i_srst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [3:0] i_reg_addr = 4'h0;
    logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata, i_conv_data, o_io_wdata;
    logic [9:0] o_io_addr;
    logic [1:0] o_conv_format, o_mux_chan;
    logic o_irq, i_conv_status, o_dma_cycle_qualifier, o_host_io_read_n, o_host_io_write_n;
    logic o_io_wdata_oe, o_conv_cs_n, o_conv_ce_n, o_conv_rw, o_hold;
    logic mute = 1'b0;
    int miscompares = 0, n_compared = 0;
    agl_host #(.CONV_WAIT_CYC(50)) dut_u (.i_clock, .i_srst, .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_irq, .i_conv_status, .i_conv_data, .o_io_addr,
        .o_dma_cycle_qualifier, .o_host_io_read_n, .o_host_io_write_n, .o_io_wdata,
        .o_io_wdata_oe, .o_conv_cs_n, .o_conv_ce_n, .o_conv_rw, .o_conv_format, .o_mux_chan,
        .o_hold);
    agl_conv_model #(.CONV_CYC(20)) conv_u (.i_clock(i_clock), .i_cs_n(o_conv_cs_n),
        .i_ce_n(o_conv_ce_n), .i_rw(o_conv_rw), .i_format(o_conv_format), .i_chan(o_mux_chan),
        .i_mute(mute), .o_status(i_conv_status), .o_data(i_conv_data));
    initial forever #5 i_clock = ~i_clock;
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
        #1 d = o_reg_rdata;
    endtask
    // polls busy and channel-pending; a stuck flag ends the run rather than hanging it
    task automatic wait_idle();
        logic [7:0] st;
        repeat (2) @(posedge i_clock);
        for (int i = 0; i < 400; i++) begin
            reg_rd(`AGL_REG_STATUS, st);
            if (st[1:0] === 2'b00) return;
        end
        miscompares++;
        $display("BAD t=%0t status=%h exp=%h", $time, st, 8'h00);
        stop_test();
    endtask
    task automatic test_convert();
        logic [7:0] d;
        reg_wr(`AGL_REG_IRQ_MASK, 8'h01);
        for (int f = 0; f < 4; f++) begin
            reg_wr(`AGL_REG_CHAN, 8'(3 - f));
            wait_idle();
            check({6'h0, o_mux_chan}, 8'(3 - f));
            reg_wr(`AGL_REG_CTRL, 8'h04 | 8'(f));
            wait_idle();
            check({7'h0, o_irq}, 8'h01);
            reg_rd(`AGL_REG_RESULT, d);
            check(d, {4'hA, 2'(3 - f), 2'(f)});
            reg_wr(`AGL_REG_IRQ_STAT, 8'h01);
            @(posedge i_clock);
            #1 check({7'h0, o_irq}, 8'h00);
        end
        $display("test_convert done");
    endtask
    task automatic test_refuse();
        logic [7:0] d;
        reg_wr(`AGL_REG_IRQ_MASK, 8'h00);
        reg_wr(`AGL_REG_CTRL, 8'h05);
        reg_wr(`AGL_REG_CTRL, 8'h06);
        reg_wr(`AGL_REG_CHAN, 8'h02);
        wait_idle();
        reg_rd(`AGL_REG_IRQ_STAT, d);
        check(d, 8'h01);
        check({7'h0, o_irq}, 8'h00);
        reg_rd(`AGL_REG_RESULT, d);
        check(d, 8'hA1);
        check({6'h0, o_mux_chan}, 8'h00);
        reg_rd(4'hF, d);
        check(d, 8'h00);
        reg_wr(`AGL_REG_IRQ_STAT, 8'h01);
        $display("test_refuse done");
    endtask
    // a converter that never answers must end in the timeout flag, with no result read
    task automatic test_timeout();
        logic [7:0] d;
        mute <= 1'b1;
        reg_wr(`AGL_REG_IRQ_MASK, 8'h02);
        reg_wr(`AGL_REG_CTRL, 8'h04);
        wait_idle();
        reg_rd(`AGL_REG_IRQ_STAT, d);
        check(d, 8'h02);
        check({7'h0, o_irq}, 8'h01);
        reg_rd(`AGL_REG_RESULT, d);
        check(d, 8'hA1);
        reg_wr(`AGL_REG_IRQ_STAT, 8'h02);
        mute <= 1'b0;
        $display("test_timeout done");
    endtask
    initial begin
        repeat (12) @(posedge i_clock);
        i_srst <= 1'b0;
        #1 check({7'h0, o_dma_cycle_qualifier}, 8'h01);
        repeat (2) @(posedge i_clock);
        #1 check({7'h0, o_dma_cycle_qualifier}, 8'h00);
        check({6'h0, o_mux_chan}, 8'h00);
        test_convert();
        test_refuse();
        test_timeout();
        stop_test();
    end
endmodule
